// *** pce_pkg.sv ***
// Package for the PCI command enable bits block
package pce_pkg;

  localparam logic [11:0] PCE_CMD_OFFSET = 12'h004;
  localparam logic [11:0] PCE_CACHE_OFFSET = 12'h00c;
  localparam logic [11:0] PCE_STATUS_OFFSET = 12'h010;
  localparam logic [11:0] PCE_ID_OFFSET = 12'h014;

  localparam int PCE_BIT_IO = 0;
  localparam int PCE_BIT_MEM = 1;
  localparam int PCE_BIT_MASTER = 2;
  localparam int PCE_BIT_SPECIAL = 3;
  localparam int PCE_BIT_WINV = 4;

  localparam logic [4:0] PCE_CMD_RESET = 5'h00;
  localparam logic [4:0] PCE_CMD_WRITABLE = 5'h17;
  localparam logic [7:0] PCE_CACHE_RESET = 8'h00;
  localparam logic [31:0] PCE_ID_VALUE = 32'h00c0_ffee;

  localparam logic [3:0] PCE_CMD_MEM_WRITE = 4'h7;
  localparam logic [3:0] PCE_CMD_MEM_WRITE_INV = 4'hf;
  localparam logic [3:0] PCE_CMD_SPECIAL = 4'h1;

  localparam logic [1:0] PCE_HTRANS_NONSEQ = 2'h2;

  typedef struct packed {
    logic valid;
    logic [31:0] address;
    logic [15:0] level;
    logic [15:0] count;
  } pce_chan_req_type;

  typedef struct packed {
    logic io_space_enable;
    logic memory_space_enable;
    logic bus_master_enable;
    logic write_invalidate_enable;
  } pce_enables_type;

endpackage

// *** pce_decode.sv ***
// Write-invalidate qualifier for one master channel
`timescale 1ns/100ps
module pce_decode (
  input wire logic hclk,
  input wire logic hresetn,
  input wire pce_pkg::pce_chan_req_type req,
  input wire logic write_invalidate_enable,
  input wire logic [7:0] cache_size,
  output logic [3:0] write_command
);
  import pce_pkg::*;

  typedef struct packed {
    logic [3:0] cmd;
  } pce_dec_state_type;

  pce_dec_state_type state_q;
  pce_dec_state_type state_d;

  // Cache size is in 32-bit words, so a line is cache_size*4 bytes
  function automatic logic line_aligned(input logic [31:0] addr, input logic [7:0] size);
    logic [31:0] mask;
    mask = ({24'h000000, size} << 2) - 32'h0000_0001;
    return (addr & mask) == 32'h0000_0000;
  endfunction

  always_comb begin
    state_d = state_q;
    state_d.cmd = PCE_CMD_MEM_WRITE;
    if (req.valid && write_invalidate_enable && cache_size != 8'h00 &&
        req.level >= {8'h00, cache_size} && req.count >= {8'h00, cache_size} &&
        line_aligned(req.address, cache_size)) begin
      state_d.cmd = PCE_CMD_MEM_WRITE_INV;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= '{cmd: PCE_CMD_MEM_WRITE};
    end else begin
      state_q <= state_d;
    end
  end

  assign write_command = state_q.cmd;
endmodule

// *** pce_top.sv ***
// Command enable bits with AHB-Lite register access and target/master gating
//
// Register access over AHB-Lite and the register offsets were decided locally.
`timescale 1ns/100ps
module pce_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire pce_pkg::pce_chan_req_type data_chan,
  input wire pce_pkg::pce_chan_req_type cmd_chan,
  output logic [3:0] data_write_command,
  output logic [3:0] cmd_write_command,
  input wire logic master_want,
  input wire logic [3:0] master_cmd,
  output logic master_request,
  input wire logic io_hit,
  input wire logic mem_hit,
  input wire logic rom_hit,
  input wire logic special_seen,
  output logic target_claim,
  output logic special_claim,
  output pce_pkg::pce_enables_type enables
);
  import pce_pkg::*;

  typedef struct packed {
    logic [4:0] cmd;
    logic [7:0] cache;
    logic wr_pend;
    logic [11:0] wr_addr;
    logic [31:0] rdata;
    logic master_request;
    logic target_claim;
    logic [2:0] claims;
  } pce_state_type;

  pce_state_type state_q;
  pce_state_type state_d;
  logic [3:0] data_cmd_w;
  logic [3:0] cmd_cmd_w;

  function automatic logic [31:0] read_mux(input pce_state_type s, input logic [11:0] a);
    logic [31:0] r;
    r = 32'h0000_0000;
    if (a == PCE_CMD_OFFSET) begin
      r = {27'h0000000, s.cmd & PCE_CMD_WRITABLE};
    end else if (a == PCE_CACHE_OFFSET) begin
      r = {24'h000000, s.cache};
    end else if (a == PCE_STATUS_OFFSET) begin
      r = {29'h00000000, s.claims};
    end else if (a == PCE_ID_OFFSET) begin
      r = PCE_ID_VALUE;
    end
    return r;
  endfunction

  always_comb begin
    logic bm;
    logic accept;
    bm = state_q.cmd[PCE_BIT_MASTER];
    accept = hsel && hready && htrans == PCE_HTRANS_NONSEQ;
    state_d = state_q;
    if (state_q.wr_pend) begin
      if (state_q.wr_addr == PCE_CMD_OFFSET) begin
        state_d.cmd = hwdata[4:0] & PCE_CMD_WRITABLE;
      end else if (state_q.wr_addr == PCE_CACHE_OFFSET) begin
        state_d.cache = hwdata[7:0];
      end
    end
    state_d.wr_pend = accept && hwrite;
    state_d.wr_addr = {haddr[11:2], 2'b00};
    if (accept && !hwrite) begin
      // Forward a write whose data phase ends now, so write then read back to back is coherent
      state_d.rdata = read_mux(state_d, {haddr[11:2], 2'b00});
    end
    // Special command codes are never let out as master requests
    state_d.master_request = master_want && bm &&
                             master_cmd != PCE_CMD_SPECIAL;
    state_d.target_claim = (io_hit && state_q.cmd[PCE_BIT_IO]) ||
                           (mem_hit && state_q.cmd[PCE_BIT_MEM]) ||
                           (rom_hit && state_q.cmd[PCE_BIT_MEM]);
    state_d.claims = {io_hit && state_q.cmd[PCE_BIT_IO], mem_hit && state_q.cmd[PCE_BIT_MEM],
                      rom_hit && state_q.cmd[PCE_BIT_MEM]};
    if (special_seen) begin
      state_d.claims = state_d.claims;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= '{cmd: PCE_CMD_RESET, cache: PCE_CACHE_RESET, wr_pend: 1'b0,
                   wr_addr: 12'h000, rdata: 32'h0000_0000, master_request: 1'b0,
                   target_claim: 1'b0, claims: 3'h0};
    end else begin
      state_q <= state_d;
    end
  end

  // Both channels share the one cache size setting
  pce_decode u_data (
    .hclk(hclk),
    .hresetn(hresetn),
    .req(data_chan),
    .write_invalidate_enable(state_q.cmd[PCE_BIT_WINV]),
    .cache_size(state_q.cache),
    .write_command(data_cmd_w)
  );

  pce_decode u_cmd (
    .hclk(hclk),
    .hresetn(hresetn),
    .req(cmd_chan),
    .write_invalidate_enable(state_q.cmd[PCE_BIT_WINV]),
    .cache_size(state_q.cache),
    .write_command(cmd_cmd_w)
  );

  assign data_write_command = data_cmd_w;
  assign cmd_write_command = cmd_cmd_w;
  assign hrdata = state_q.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign master_request = state_q.master_request;
  assign target_claim = state_q.target_claim;
  assign special_claim = 1'b0;
  assign enables = '{io_space_enable: state_q.cmd[PCE_BIT_IO],
                     memory_space_enable: state_q.cmd[PCE_BIT_MEM],
                     bus_master_enable: state_q.cmd[PCE_BIT_MASTER],
                     write_invalidate_enable: state_q.cmd[PCE_BIT_WINV]};
endmodule

// *** pce_peer.sv ***
// PCI side address decoder stand-in feeding the decode hits
`timescale 1ns/100ps
module pce_peer (
  input wire logic hclk,
  input wire logic [2:0] hit_req,
  output logic io_hit,
  output logic mem_hit,
  output logic rom_hit
);
  // Registered like a real decoder, so hits never move on the sampling edge
  always_ff @(posedge hclk) begin
    {rom_hit, mem_hit, io_hit} <= hit_req;
  end
endmodule

// *** pce_top_asserts.sv ***
// Concurrent checks on the command enable bits block
`timescale 1ns/100ps
module pce_top_asserts (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic [3:0] data_write_command,
  input wire logic master_want,
  input wire logic [3:0] master_cmd,
  input wire logic master_request,
  input wire logic io_hit,
  input wire logic mem_hit,
  input wire logic rom_hit,
  input wire logic target_claim,
  input wire logic special_claim,
  input wire pce_pkg::pce_enables_type enables
);
  import pce_pkg::*;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire logic mst = enables.bus_master_enable;
  wire logic wi = enables.write_invalidate_enable;
  // A decode hit only counts when its own space is enabled
  wire logic hit_ok = (io_hit && enables.io_space_enable) ||
    ((mem_hit || rom_hit) && enables.memory_space_enable);
  sequence s_rd;
    hsel && hready && htrans == PCE_HTRANS_NONSEQ && !hwrite && haddr == PCE_CMD_OFFSET;
  endsequence
  property p_rd; s_rd |=> hrdata[4:0] == {wi, 1'b0, mst, enables.memory_space_enable,
    enables.io_space_enable}; endproperty
  a_rd: assert property (p_rd) else $error("command read wrong");
  property p_mwr; !wi |=> data_write_command == PCE_CMD_MEM_WRITE; endproperty
  a_mwr: assert property (p_mwr) else $error("plain write expected");
  property p_wi; data_write_command == PCE_CMD_MEM_WRITE_INV |-> $past(wi); endproperty
  a_wi: assert property (p_wi) else $error("invalidate not enabled");
  property p_mreq; master_request |-> $past(mst) && $past(master_want); endproperty
  a_mreq: assert property (p_mreq) else $error("request without enable");
  property p_mgo; master_want && mst && master_cmd != PCE_CMD_SPECIAL
    |=> master_request; endproperty
  a_mgo: assert property (p_mgo) else $error("request missing");
  property p_spc; master_cmd == PCE_CMD_SPECIAL |=> !master_request && !special_claim; endproperty
  a_spc: assert property (p_spc) else $error("special cycle used");
  property p_clm; hit_ok |=> target_claim; endproperty
  a_clm: assert property (p_clm) else $error("claim missing");
  property p_ign; !hit_ok |=> !target_claim; endproperty
  a_ign: assert property (p_ign) else $error("claim while disabled");
endmodule

// *** pci_command_enable_bits_bench.sv ***
// Self-checking bench for the command enable bits block
`timescale 1ns/100ps
module pci_command_enable_bits_bench;
  import pce_pkg::*;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, master_want = 1'b0;
  logic special_seen = 1'b0, hresp, hreadyout, master_request, target_claim, special_claim;
  logic io_hit, mem_hit, rom_hit;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hit_req = 3'h0;
  logic [3:0] master_cmd = 4'h0, data_write_command, cmd_write_command;
  logic [11:0] haddr = 12'h000;
  logic [31:0] hwdata = 32'h0, hrdata;
  pce_chan_req_type data_chan = '0, cmd_chan = '0;
  pce_enables_type enables;
  int fail_count = 0, n_compared = 0;
  pce_top u_pce_top (.hsize(3'h2), .hready(hreadyout), .*);
  pce_peer u_pce_peer (.*);
  initial forever #12.5 hclk = ~hclk;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Reads compare against d; no wait-state count is assumed
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= PCE_HTRANS_NONSEQ;
    hwrite <= wr;
    haddr <= a;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    if (!wr) chk(hrdata, d);
    // Enable outputs follow the command bits; the response is always OKAY
    if (!wr && a == PCE_CMD_OFFSET) chk({27'h0, hresp, enables}, {27'h0, 1'b0, d[0], d[1], d[2], d[4]});
  endtask
  // Hits pass the peer's stage and then the claim register
  task automatic sig(input logic [10:0] exp);
    repeat (3) @(posedge hclk);
    chk({21'h0, data_write_command, cmd_write_command, master_request, target_claim,
         special_claim}, {21'h0, exp});
  endtask
  task automatic end_sim();
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (2000) @(posedge hclk);
    fail_count++;
    end_sim();
  end
  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    sig({4'h7, 4'h7, 3'h0});
    xfer(1'b0, PCE_CMD_OFFSET, 32'h0);
    xfer(1'b0, 12'h020, 32'h0);
    xfer(1'b1, PCE_CACHE_OFFSET, 32'h4);
    xfer(1'b1, PCE_CMD_OFFSET, 32'h1f);
    xfer(1'b0, PCE_CMD_OFFSET, 32'h17);
    {master_want, master_cmd, special_seen, hit_req} <= {1'b1, 4'h7, 1'b1, 3'h7};
    data_chan <= '{1'b1, 32'h40, 16'h4, 16'h4};
    cmd_chan <= '{1'b1, 32'h48, 16'h8, 16'h8};
    sig({4'hf, 4'h7, 3'h6});
    data_chan.level <= 16'h3;
    cmd_chan <= '{1'b1, 32'h50, 16'h4, 16'h4};
    {master_cmd, hit_req} <= {PCE_CMD_SPECIAL, 3'h4};
    sig({4'h7, 4'hf, 3'h2});
    cmd_chan.count <= 16'h3;
    {master_cmd, hit_req} <= {4'h7, 3'h1};
    sig({4'h7, 4'h7, 3'h6});
    data_chan.level <= 16'h4;
    xfer(1'b1, PCE_CMD_OFFSET, 32'h8);
    xfer(1'b0, PCE_CMD_OFFSET, 32'h0);
    hit_req <= 3'h7;
    sig({4'h7, 4'h7, 3'h0});
    xfer(1'b1, PCE_CMD_OFFSET, 32'h2);
    sig({4'h7, 4'h7, 3'h2});
    hit_req <= 3'h1;
    sig({4'h7, 4'h7, 3'h0});
    end_sim();
  end
endmodule
bind pce_top pce_top_asserts u_pce_top_asserts (.*);
